// ===== rtl/pcxb_regs.svh
// constants of the priority crossbar pin assignment block
// Notes on behaviour
// - pin transition raises interrupt or wake event
// - events work on skipped or crossbar pins, digital only
// - functions ranked fixed, serial port highest
// - each enabled resource except the serial port takes lowest free pin
// - an assigned pin is passed over afterwards
// - skipped pins count as occupied, never assigned except the fixed serial pins
// - serial transmit on P0.4, receive on P0.5
// - two-wire bus data and clock requested together; with one free pin left, data takes it and clock gets none
// - serial transmit and receive allocated together
// - leftover unskipped pins stay general port I/O
// - slave-select mode field picks 3 or 4 wire
// - slave select takes a pin only in 4-wire
// - two selection words give per-resource enables
// - nothing driven until global enable is set
// - input mode 1 digital; analog pins read 0
`ifndef PCXB_REGS_SVH
`define PCXB_REGS_SVH
// ----------------------------------------
// sizes
// ----------------------------------------
`define PCXB_NPIN 24
`define PCXB_NFN 17
// ----------------------------------------
// function slots in priority order
// ----------------------------------------
`define PCXB_FN_TX 0
`define PCXB_FN_RX 1
`define PCXB_FN_SCK 2
`define PCXB_FN_MISO 3
`define PCXB_FN_MOSI 4
`define PCXB_FN_SSEL 5
`define PCXB_FN_SDA 6
`define PCXB_FN_SCL 7
`define PCXB_FN_CMP 8
`define PCXB_FN_CMPA 9
`define PCXB_FN_CLKOUT 10
`define PCXB_FN_CNT0 11
`define PCXB_FN_CNT1 12
`define PCXB_FN_CNT2 13
`define PCXB_FN_CNTCLK 14
`define PCXB_FN_TMR0 15
`define PCXB_FN_TMR1 16
// ----------------------------------------
// selection word fields
// ----------------------------------------
`define PCXB_A_UART 0
`define PCXB_A_SPI 1
`define PCXB_A_SMB 2
`define PCXB_A_CMP 3
`define PCXB_A_CMPA 4
`define PCXB_A_CLKOUT 5
`define PCXB_B_PCA_LSB 0
`define PCXB_B_PCA_MSB 1
`define PCXB_B_CNTCLK 3
`define PCXB_B_TMR0 4
`define PCXB_B_TMR1 5
`define PCXB_B_XBAR_EN 6
`define PCXB_SS_3WIRE 2'h0
// ----------------------------------------
// fixed pins, interrupt config, reset values
// ----------------------------------------
`define PCXB_TX_MASK 24'h000010
`define PCXB_RX_MASK 24'h000020
`define PCXB_UART_MASK 24'h000030
`define PCXB_IRQ_POL 3
`define PCXB_RST_OE_N 24'hFFFFFF
`endif

// ===== rtl/pcxb_pkg.sv
// types of the priority crossbar pin assignment block
package pcxb_pkg;
	typedef logic [4:0] pcxb_idx_t;
	typedef logic [23:0] pcxb_pins_t;
	typedef logic [16:0] pcxb_fns_t;
endpackage

// ===== rtl/pcxb_if.sv
// internal carrier between crossbar top, allocator and event logic
`timescale 1ns/10ps
`default_nettype none
`include "pcxb_regs.svh"
interface pcxb_if;
	pcxb_pkg::pcxb_fns_t req;
	pcxb_pkg::pcxb_pins_t skip;
	logic uart_en;
	pcxb_pkg::pcxb_pins_t pin_taken;
	pcxb_pkg::pcxb_idx_t pin_fn [`PCXB_NPIN];
	pcxb_pkg::pcxb_idx_t fn_pin [`PCXB_NFN];
	pcxb_pkg::pcxb_fns_t fn_ok;
	pcxb_pkg::pcxb_pins_t din;
	pcxb_pkg::pcxb_pins_t dig;
	logic [7:0] irq_cfg;
	logic [15:0] pm_mask;
	logic [15:0] pm_val;
	logic ev0;
	logic ev1;
	logic evm;
	modport alloc (input req, skip, uart_en, output pin_taken, pin_fn, fn_pin, fn_ok);
	modport evt (input din, dig, irq_cfg, pm_mask, pm_val, output ev0, ev1, evm);
	modport top (output req, skip, uart_en, din, dig, irq_cfg, pm_mask, pm_val,
		input pin_taken, pin_fn, fn_pin, fn_ok, ev0, ev1, evm);
endinterface
`default_nettype wire

// ===== rtl/pcxb_alloc.sv
// priority pin allocator: fixes the serial pair, walks the other functions in order, grants lowest free pin
`timescale 1ns/10ps
`default_nettype none
`include "pcxb_regs.svh"
module pcxb_alloc (
	// carrier
	pcxb_if.alloc xb
);
	pcxb_pkg::pcxb_pins_t gnt [`PCXB_NFN];
	pcxb_pkg::pcxb_pins_t used [`PCXB_FN_SCK:`PCXB_NFN];

	// one-hot to pin index
	function automatic pcxb_pkg::pcxb_idx_t enc(input pcxb_pkg::pcxb_pins_t v);
		pcxb_pkg::pcxb_idx_t r;
		r = '0;
		for (int i = 0; i < `PCXB_NPIN; i++) begin
			if (v[i]) begin
				r = 5'(i);
			end
		end
		return r;
	endfunction

	// serial pair is fixed, pinned regardless of skip
	assign gnt[`PCXB_FN_TX] = xb.uart_en ? `PCXB_TX_MASK : '0;
	assign gnt[`PCXB_FN_RX] = xb.uart_en ? `PCXB_RX_MASK : '0;
	// skipped pins and the fixed serial pins start out occupied
	assign used[`PCXB_FN_SCK] = xb.skip | (xb.uart_en ? `PCXB_UART_MASK : '0);

	// ----------------------------------------
	// priority chain
	// ----------------------------------------
	for (genvar f = 0; f < `PCXB_NFN; f++) begin : g_fn
		if (f >= `PCXB_FN_SCK) begin : g_chain
			pcxb_pkg::pcxb_pins_t free;
			// lowest free pin, then mark it used for later slots
			assign free = ~used[f];
			assign gnt[f] = xb.req[f] ? (free & (~free + 24'h000001)) : '0;
			assign used[f+1] = used[f] | gnt[f];
		end
		assign xb.fn_ok[f] = |gnt[f];
		assign xb.fn_pin[f] = enc(gnt[f]);
	end

	// pins left over stay port I/O
	assign xb.pin_taken = (used[`PCXB_NFN] & ~xb.skip) | gnt[`PCXB_FN_TX] | gnt[`PCXB_FN_RX];

	// owner of each pin
	for (genvar p = 0; p < `PCXB_NPIN; p++) begin : g_pin
		always_comb begin
			xb.pin_fn[p] = '0;
			for (int f = 0; f < `PCXB_NFN; f++) begin
				if (gnt[f][p]) begin
					xb.pin_fn[p] = 5'(f);
				end
			end
		end
	end
endmodule
`default_nettype wire

// ===== rtl/pcxb_event.sv
// external interrupt and port match edge detection
`timescale 1ns/10ps
`default_nettype none
`include "pcxb_regs.svh"
module pcxb_event (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// carrier
	pcxb_if.evt ev
);
	logic [2:0] sel0;
	logic [2:0] sel1;
	logic lvl0;
	logic lvl1;
	logic mism;
	logic prev0_ff;
	logic prev1_ff;
	logic prevm_ff;
	logic ev0_ff;
	logic ev1_ff;
	logic evm_ff;

	// active level per selected pin, analog pins never fire
	assign sel0 = ev.irq_cfg[2:0];
	assign sel1 = ev.irq_cfg[6:4];
	assign lvl0 = ev.dig[sel0] & (ev.din[sel0] ~^ ev.irq_cfg[`PCXB_IRQ_POL]);
	assign lvl1 = ev.dig[sel1] & (ev.din[sel1] ~^ ev.irq_cfg[`PCXB_IRQ_POL+4]);
	// any masked digital pin differing from its match value
	assign mism = |((ev.din[15:0] ^ ev.pm_val) & ev.pm_mask & ev.dig[15:0]);

	// edge into the active state gives a one-cycle event
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			prev0_ff <= 1'b0;
			prev1_ff <= 1'b0;
			prevm_ff <= 1'b0;
			ev0_ff <= 1'b0;
			ev1_ff <= 1'b0;
			evm_ff <= 1'b0;
		end else begin
			prev0_ff <= lvl0;
			prev1_ff <= lvl1;
			prevm_ff <= mism;
			ev0_ff <= lvl0 & ~prev0_ff;
			ev1_ff <= lvl1 & ~prev1_ff;
			evm_ff <= mism & ~prevm_ff;
		end
	end

	assign ev.ev0 = ev0_ff;
	assign ev.ev1 = ev1_ff;
	assign ev.evm = evm_ff;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence s_act0;
		!lvl0 ##1 lvl0;
	endsequence
	sequence s_actm;
		!mism ##1 mism;
	endsequence
	property p_int0_edge;
		@(posedge mclk_i) disable iff (rst_i) s_act0 |=> ev0_ff;
	endproperty
	a_int0_edge: assert property (p_int0_edge) else $error("int0 edge missed");
	property p_match_edge;
		@(posedge mclk_i) disable iff (rst_i) s_actm |=> evm_ff ##1 !evm_ff;
	endproperty
	a_match_edge: assert property (p_match_edge) else $error("match edge missed");
	property p_analog_quiet;
		@(posedge mclk_i) disable iff (rst_i) !ev.dig[sel1] |=> !ev1_ff;
	endproperty
	a_analog_quiet: assert property (p_analog_quiet) else $error("analog pin fired");
endmodule
`default_nettype wire

// ===== rtl/pcxb_top.sv
// priority crossbar: routes peripheral signals and port I/O to pads
`timescale 1ns/10ps
`default_nettype none
`include "pcxb_regs.svh"
module pcxb_top (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// configuration
	input wire logic [7:0] resource_select_a_i,
	input wire logic [7:0] resource_select_b_i,
	input wire logic [1:0] slave_select_mode_field_i,
	input wire logic [23:0] pin_skip_mask_i,
	input wire logic [23:0] pin_input_mode_i,
	input wire logic [7:0] ext_irq_pin_config_i,
	input wire logic [7:0] port0_match_mask_i,
	input wire logic [7:0] port0_match_value_i,
	input wire logic [7:0] port1_match_mask_i,
	input wire logic [7:0] port1_match_value_i,
	// peripheral side
	input wire logic [16:0] func_out_i,
	input wire logic [16:0] func_drive_i,
	output logic [16:0] func_in_o,
	// port I/O side
	input wire logic [23:0] gpio_out_i,
	input wire logic [23:0] gpio_drive_i,
	output logic [23:0] port_read_o,
	// pads
	input wire logic [23:0] pad_i,
	output logic [23:0] pad_o,
	output logic [23:0] pad_oe_n_o,
	// status and events
	output logic [23:0] pin_assigned_o,
	output logic ext_irq0_o,
	output logic ext_irq1_o,
	output logic port_match_o,
	output logic wake_o
);
	pcxb_if xb ();

	logic xen;
	logic four_wire;
	logic [1:0] pca_n;
	pcxb_pkg::pcxb_pins_t dig;
	pcxb_pkg::pcxb_pins_t din;
	pcxb_pkg::pcxb_pins_t nxt_pad;
	pcxb_pkg::pcxb_pins_t nxt_oe_n;
	pcxb_pkg::pcxb_fns_t nxt_fin;
	pcxb_pkg::pcxb_pins_t pad_ff;
	pcxb_pkg::pcxb_pins_t oe_n_ff;
	pcxb_pkg::pcxb_fns_t fin_ff;
	pcxb_pkg::pcxb_pins_t read_ff;
	pcxb_pkg::pcxb_pins_t asg_ff;
	logic wake_ff;

	// ----------------------------------------
	// resource requests
	// ----------------------------------------
	// global enable and slave-select mode
	assign xen = resource_select_b_i[`PCXB_B_XBAR_EN];
	assign four_wire = slave_select_mode_field_i != `PCXB_SS_3WIRE;
	assign pca_n = resource_select_b_i[`PCXB_B_PCA_MSB:`PCXB_B_PCA_LSB];

	// one enable per resource drives the request vector
	assign xb.uart_en = resource_select_a_i[`PCXB_A_UART];
	assign xb.req[`PCXB_FN_TX] = xb.uart_en;
	assign xb.req[`PCXB_FN_RX] = xb.uart_en;
	assign xb.req[`PCXB_FN_SCK] = resource_select_a_i[`PCXB_A_SPI];
	assign xb.req[`PCXB_FN_MISO] = resource_select_a_i[`PCXB_A_SPI];
	assign xb.req[`PCXB_FN_MOSI] = resource_select_a_i[`PCXB_A_SPI];
	assign xb.req[`PCXB_FN_SSEL] = resource_select_a_i[`PCXB_A_SPI] & four_wire;
	assign xb.req[`PCXB_FN_SDA] = resource_select_a_i[`PCXB_A_SMB];
	assign xb.req[`PCXB_FN_SCL] = resource_select_a_i[`PCXB_A_SMB];
	assign xb.req[`PCXB_FN_CMP] = resource_select_a_i[`PCXB_A_CMP];
	assign xb.req[`PCXB_FN_CMPA] = resource_select_a_i[`PCXB_A_CMPA];
	assign xb.req[`PCXB_FN_CLKOUT] = resource_select_a_i[`PCXB_A_CLKOUT];
	// counter-array outputs enabled as a count of channels
	assign xb.req[`PCXB_FN_CNT0] = pca_n >= 2'h1;
	assign xb.req[`PCXB_FN_CNT1] = pca_n >= 2'h2;
	assign xb.req[`PCXB_FN_CNT2] = pca_n == 2'h3;
	assign xb.req[`PCXB_FN_CNTCLK] = resource_select_b_i[`PCXB_B_CNTCLK];
	assign xb.req[`PCXB_FN_TMR0] = resource_select_b_i[`PCXB_B_TMR0];
	assign xb.req[`PCXB_FN_TMR1] = resource_select_b_i[`PCXB_B_TMR1];
	assign xb.skip = pin_skip_mask_i;

	// ----------------------------------------
	// input mode and event wiring
	// ----------------------------------------
	// analog pins lose their digital receiver
	assign dig = pin_input_mode_i;
	assign din = pad_i & dig;
	assign xb.din = din;
	assign xb.dig = dig;
	assign xb.irq_cfg = ext_irq_pin_config_i;
	assign xb.pm_mask = {port1_match_mask_i, port0_match_mask_i};
	assign xb.pm_val = {port1_match_value_i, port0_match_value_i};

	pcxb_alloc u_alloc (
		.xb (xb.alloc)
	);

	pcxb_event u_event (
		.mclk_i (mclk_i),
		.rst_i (rst_i),
		.ev (xb.evt)
	);

	// ----------------------------------------
	// pad routing
	// ----------------------------------------
	for (genvar p = 0; p < `PCXB_NPIN; p++) begin : g_pad
		logic own;
		logic drv;
		pcxb_pkg::pcxb_idx_t fn;
		// owned pins follow their peripheral, others are port I/O
		assign fn = xb.pin_fn[p];
		assign own = xb.pin_taken[p];
		assign nxt_pad[p] = own ? func_out_i[fn] : gpio_out_i[p];
		assign drv = own ? func_drive_i[fn] : gpio_drive_i[p];
		// no drive before global enable, none on analog pins
		assign nxt_oe_n[p] = ~(xen & dig[p] & drv);
	end

	// peripheral inputs come from their granted pin
	for (genvar f = 0; f < `PCXB_NFN; f++) begin : g_fin
		assign nxt_fin[f] = xen & xb.fn_ok[f] & din[xb.fn_pin[f]];
	end

	// registered outputs
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			pad_ff <= '0;
			oe_n_ff <= `PCXB_RST_OE_N;
			fin_ff <= '0;
			read_ff <= '0;
			asg_ff <= '0;
			wake_ff <= 1'b0;
		end else begin
			pad_ff <= nxt_pad;
			oe_n_ff <= nxt_oe_n;
			fin_ff <= nxt_fin;
			read_ff <= din;
			asg_ff <= xen ? xb.pin_taken : '0;
			wake_ff <= xb.ev0 | xb.ev1 | xb.evm;
		end
	end

	assign pad_o = pad_ff;
	assign pad_oe_n_o = oe_n_ff;
	assign func_in_o = fin_ff;
	assign port_read_o = read_ff;
	assign pin_assigned_o = asg_ff;
	assign ext_irq0_o = xb.ev0;
	assign ext_irq1_o = xb.ev1;
	assign port_match_o = xb.evm;
	assign wake_o = wake_ff;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	pcxb_pkg::pcxb_pins_t free;
	pcxb_pkg::pcxb_pins_t xbp;
	pcxb_pkg::pcxb_pins_t below;
	// free unskipped pins and pins sitting below any crossbar pin
	assign free = ~xb.pin_taken & ~pin_skip_mask_i & ~(xb.uart_en ? `PCXB_UART_MASK : 24'h000000);
	assign xbp = xb.pin_taken & ~(xb.uart_en ? `PCXB_UART_MASK : 24'h000000);
	always_comb begin
		below = '0;
		for (int i = `PCXB_NPIN - 2; i >= 0; i--) begin
			below[i] = below[i+1] | xbp[i+1];
		end
	end

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	property p_off_quiet;
		!$past(xen) |-> (&pad_oe_n_o && func_in_o == '0);
	endproperty
	a_off_quiet: assert property (p_off_quiet) else $error("drive while crossbar off");
	property p_tx_fixed;
		$past(xen && xb.uart_en) |-> pad_o[4] == $past(func_out_i[`PCXB_FN_TX]);
	endproperty
	a_tx_fixed: assert property (p_tx_fixed) else $error("transmit not on pin 4");
	property p_rx_fixed;
		$past(xen && xb.uart_en) |-> func_in_o[`PCXB_FN_RX] == $past(din[5]);
	endproperty
	a_rx_fixed: assert property (p_rx_fixed) else $error("receive not from pin 5");
	property p_skip_kept;
		(xbp & pin_skip_mask_i) == '0;
	endproperty
	a_skip_kept: assert property (p_skip_kept) else $error("skipped pin assigned");
	property p_distinct;
		$countones(xb.pin_taken) == $countones(xb.fn_ok);
	endproperty
	a_distinct: assert property (p_distinct) else $error("pin given twice");
	property p_contig;
		(free & below) == '0;
	endproperty
	a_contig: assert property (p_contig) else $error("free pin below assigned pin");
	property p_pair_bus;
		xb.fn_ok[`PCXB_FN_SDA] == xb.fn_ok[`PCXB_FN_SCL] || free == '0;
	endproperty
	a_pair_bus: assert property (p_pair_bus) else $error("bus pins split");
	property p_ssel_mode;
		xb.fn_ok[`PCXB_FN_SSEL] |-> four_wire;
	endproperty
	a_ssel_mode: assert property (p_ssel_mode) else $error("slave select in 3-wire");
	property p_starve;
		|(xb.req & ~xb.fn_ok) |-> free == '0;
	endproperty
	a_starve: assert property (p_starve) else $error("request starved with pins free");
	property p_analog_read;
		(port_read_o & ~$past(pin_input_mode_i)) == '0;
	endproperty
	a_analog_read: assert property (p_analog_read) else $error("analog pin read nonzero");
	property p_wake;
		xb.ev0 |=> wake_o;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake after event");
endmodule
`default_nettype wire

// ===== verif/pcxb_pads.sv
// pad wire model: design driver, external driver and weak pull-up
`timescale 1ns/10ps
`default_nettype none
module pcxb_pads (
	// design side
	input wire logic [23:0] pad_drv_i,
	input wire logic [23:0] pad_oe_n_i,
	// external side
	input wire logic [23:0] ext_lvl_i,
	input wire logic [23:0] ext_drv_i,
	// resolved level
	output logic [23:0] pad_lvl_o
);
	// design drive wins, then the outside world, else the weak pull-up
	genvar g;
	for (g = 0; g < 24; g++) begin : g_pin
		assign pad_lvl_o[g] = !pad_oe_n_i[g] ? pad_drv_i[g] : (ext_drv_i[g] ? ext_lvl_i[g] : 1'b1);
	end
endmodule
`default_nettype wire

// ===== verif/tb.sv
// self-checking bench of the priority crossbar pin assignment block
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic mclk_i = 0, rst_i = 1;
	logic [7:0] sa = 0, sb = 0, icfg = 0, m0 = 0, v0 = 0, m1 = 0, v1 = 0;
	logic [1:0] md = 0;
	logic [23:0] skip = 0, imode = 24'hFFFFFF, gout = 24'h5A3C96, gdrv = 24'hFFFFFF;
	logic [23:0] elv = 0, edrv = 0, pad_i, pad_o, oe_n, rd, pa;
	logic [16:0] fo = 17'h0B2C5, fd = 17'h1FFFD, fin;
	logic irq0, irq1, pm, wake;
	logic [23:0] e_pa, e_pad, e_oe;
	int n_mismatch = 0, n_tests = 0;
	// ----------------------------------------
	// clock, design and pad model
	// ----------------------------------------
	initial forever #2 mclk_i = ~mclk_i;
	pcxb_top uut (.mclk_i(mclk_i), .rst_i(rst_i), .resource_select_a_i(sa), .resource_select_b_i(sb),
		.slave_select_mode_field_i(md), .pin_skip_mask_i(skip), .pin_input_mode_i(imode),
		.ext_irq_pin_config_i(icfg), .port0_match_mask_i(m0), .port0_match_value_i(v0),
		.port1_match_mask_i(m1), .port1_match_value_i(v1), .func_out_i(fo), .func_drive_i(fd),
		.func_in_o(fin), .gpio_out_i(gout), .gpio_drive_i(gdrv), .port_read_o(rd), .pad_i(pad_i),
		.pad_o(pad_o), .pad_oe_n_o(oe_n), .pin_assigned_o(pa), .ext_irq0_o(irq0), .ext_irq1_o(irq1),
		.port_match_o(pm), .wake_o(wake));
	pcxb_pads pads (.pad_drv_i(pad_o), .pad_oe_n_i(oe_n), .ext_lvl_i(elv), .ext_drv_i(edrv), .pad_lvl_o(pad_i));
	// ----------------------------------------
	// compare, verdict, watchdog
	// ----------------------------------------
	task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		#40000;
		n_mismatch++;
		stop_test();
	end
	// reference walk: priority slots take the lowest free unskipped pin
	task automatic ref_map();
		logic [23:0] occ;
		logic [16:0] req;
		logic hit;
		occ = skip;
		e_pa = 0;
		e_pad = gout;
		e_oe = ~gdrv;
		req = 0;
		req[4:2] = {3{sa[1]}};
		req[5] = sa[1] && md != 2'h0;
		req[7:6] = {2{sa[2]}};
		req[10:8] = sa[5:3];
		for (int k = 0; k < 3; k++) req[11+k] = sb[1:0] > k;
		req[16:14] = sb[5:3];
		if (sa[0]) begin
			occ[5:4] = 2'h3;
			e_pa[5:4] = 2'h3;
			e_pad[5:4] = {fo[1], fo[0]};
			e_oe[5:4] = {~fd[1], ~fd[0]};
		end
		for (int s = 2; s < 17; s++) begin
			hit = 0;
			for (int p = 0; p < 24; p++) begin
				if (req[s] && !hit && !occ[p]) begin
					hit = 1;
					occ[p] = 1;
					e_pa[p] = 1;
					e_pad[p] = fo[s];
					e_oe[p] = ~fd[s];
				end
			end
		end
		if (!sb[6]) begin
			e_pa = 0;
			e_oe = 24'hFFFFFF;
		end
	endtask
	// wait for one event output, then its wake pulse
	task automatic ev(input int k, input int pn, input logic lv, input logic want);
		logic hit;
		logic [2:0] evs;
		hit = 0;
		@(posedge mclk_i) elv[pn] <= lv;
		repeat (4) begin
			@(posedge mclk_i);
			#1;
			evs = {pm, irq1, irq0};
			if (!hit && evs[k] === 1'b1) begin
				hit = 1;
				@(posedge mclk_i);
				#1;
				chk("wake", {23'h0, wake}, 24'h1);
			end
		end
		chk("event", {23'h0, hit}, {23'h0, want});
	endtask
	// ----------------------------------------
	// configuration table: a, b, mode, skip
	// ----------------------------------------
	logic [57:0] tbl [8] = '{
		{8'h02, 8'h40, 2'h0, 24'h000000, 16'h0}, {8'h3F, 8'h7B, 2'h1, 24'h000000, 16'h0},
		{8'h3F, 8'h7B, 2'h1, 24'h00010C, 16'h0}, {8'h3F, 8'h7A, 2'h2, 24'h000030, 16'h0},
		{8'h3E, 8'h79, 2'h3, 24'hFFFF00, 16'h0}, {8'h06, 8'h40, 2'h0, 24'h000041, 16'h0},
		{8'h3F, 8'h3B, 2'h1, 24'hF00000, 16'h0}, {8'h01, 8'h40, 2'h0, 24'h000000, 16'h0}};
	initial begin
		repeat (6) @(posedge mclk_i);
		rst_i <= 0;
		for (int i = 0; i < 8; i++) begin
			@(posedge mclk_i);
			{sa, sb, md, skip} <= tbl[i][57:16];
			@(posedge mclk_i);
			#1;
			ref_map();
			chk("assigned", pa, e_pa);
			chk("oe_n", oe_n, e_oe);
			chk("pad_o", pad_o & ~e_oe, e_pad & ~e_oe);
		end
		// serial receive pin carries the outside level in
		@(posedge mclk_i) begin
			edrv[5] <= 1;
			elv[5] <= 0;
		end
		repeat (2) @(posedge mclk_i);
		#1;
		chk("rx_in", {23'h0, fin[1]}, 24'h0);
		@(posedge mclk_i) elv[5] <= 1;
		repeat (2) @(posedge mclk_i);
		#1;
		chk("rx_in", {23'h0, fin[1]}, 24'h1);
		// events on a skipped general-purpose pin
		@(posedge mclk_i) begin
			{sa, sb, skip} <= {8'h00, 8'h40, 24'h000001};
			gdrv <= 24'hFFFEFE;
			edrv <= 24'h000121;
			elv <= 24'h000120;
			icfg <= 8'h08;
			m0 <= 8'h01;
		end
		repeat (3) @(posedge mclk_i);
		ev(0, 0, 1, 1);
		ev(1, 0, 0, 1);
		ev(2, 0, 1, 1);
		ev(1, 0, 0, 1);
		// port 1 match: pin 8 leaves its match value of 1
		@(posedge mclk_i) begin
			m0 <= 8'h00;
			m1 <= 8'h01;
			v1 <= 8'h01;
		end
		ev(2, 8, 0, 1);
		// analog pin: no drive, reads 0, no interrupt 0 event
		@(posedge mclk_i) begin
			imode[0] <= 0;
			gdrv[0] <= 1;
		end
		ev(0, 0, 1, 0);
		chk("read", {23'h0, rd[0]}, 24'h0);
		chk("oe_n0", {23'h0, oe_n[0]}, 24'h1);
		stop_test();
	end
endmodule
`default_nettype wire
